// ==== pkg/bsf_consts.vh ====
/*
 Constants for the band split sampler: timing counts, data widths,
 filter sizes and normalisation figures.
 Assumes a 200 MHz system clock and inclusion by bare name.
*/
`ifndef BSF_CONSTS_VH
`define BSF_CONSTS_VH
// Clock period in picoseconds
`define BSF_CLK_PS        5000
// Sample period in nanoseconds, about 10 kHz
`define BSF_SAMPLE_NS     100000
// Cycles per sample match
`define BSF_SAMPLE_CYC    ((`BSF_SAMPLE_NS * 1000) / `BSF_CLK_PS)
// Judgement refresh in milliseconds, about once a second
`define BSF_REFRESH_MS    1000
// Sample matches per refresh
`define BSF_REFRESH_CNT   ((`BSF_REFRESH_MS * 1000000) / `BSF_SAMPLE_NS)
// Samples per transfer block
`define BSF_BLOCK_LEN     256
// Converter width
`define BSF_ADC_W         12
// Normalised width
`define BSF_NORM_W        15
// Data path width (16-bit fixed point default)
`define BSF_DATA_W        16
// Bias: converter midscale
`define BSF_BIAS          12'h0800
// Default tap count and its maximum
`define BSF_TAPS          64
`define BSF_TAPS_MAX      256
// Arithmetic modes: 0 16-bit fixed, 1 32-bit fixed, 2 float
`define BSF_MODE_I16      2'h0
`define BSF_MODE_I32      2'h1
`define BSF_MODE_F32      2'h2
// Band codes shown on the indicators
`define BSF_BAND_LOW      2'h1
`define BSF_BAND_MID      2'h2
`define BSF_BAND_HIGH     2'h3
`endif

// ==== hdl/bsf_skid.v ====
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bsf_skid #(
	parameter W = 12
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output wire [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	reg [W-1:0] mem [0:1]; // Two words
	reg         wp;        // Write slot
	reg         rp;        // Read slot
	reg [1:0]   cnt;       // Fill level

	assign in_ready  = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_data  = mem[rp];

	// Pointer and level update; stall upstream when full
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (in_valid && in_ready) begin
				mem[wp] <= in_data;
				wp      <= ~wp;
			end
			if (out_valid && out_ready)
				rp <= ~rp;
			case ({in_valid && in_ready, out_valid && out_ready})
				2'b10:   cnt <= cnt + 2'h1;
				2'b01:   cnt <= cnt - 2'h1;
				default: cnt <= cnt;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== hdl/bsf_top.v ====
/*
 Sampling and three-channel FIR chain with band judgement.
 Assumes the converter answers conv_start with conv_valid and conv_data,
 switch input already debounced and synchronous to clk.
*/
// Overview of operation
// - Sample the input at about 10 kHz
// - Timer match every 100 us starts conversion
// - Buffer 256 results then pulse block done
// - Store samples as 12-bit unsigned
// - Normalise to signed 15-bit by bias, scale
// - Feed low, band and high FIR channels
// - Switch press toggles filtering on and off
// - Judge band, show distinct indicator pattern
// - 16-bit fixed only, arith_mode is ignored
// - 64 taps fixed; the 256 maximum is defined but unused
// - Refresh indicator about once per second
`timescale 1ns/1ps
`default_nettype none
`include "bsf_consts.vh"
module bsf_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        conv_valid,
	input  wire [11:0] conv_data,
	input  wire        filter_switch,
	input  wire [1:0]  arith_mode,
	output reg         conv_start,
	output reg         block_done,
	output reg         filter_on,
	output reg  [1:0]  led,
	output reg  [15:0] ch0_out,
	output reg  [15:0] ch1_out,
	output reg  [15:0] ch2_out,
	output reg         ch_valid
);
	localparam TAPS = `BSF_TAPS; // Fixed tap count
	// Sequencer states, one-hot
	localparam S_IDLE = 4'b0001;
	localparam S_MAC  = 4'b0010;
	localparam S_OUT  = 4'b0100;
	localparam S_HOLD = 4'b1000;

	reg  [14:0] tmr;              // Match timer count
	reg  [7:0]  wr_idx;           // Input buffer write index
	reg  [11:0] in_buf [0:255];   // Raw 12-bit samples
	reg  [15:0] hist [0:TAPS-1];  // Normalised history line
	reg  [3:0]  state;            // Sequencer state
	reg  [5:0]  tap;              // Current tap
	reg  signed [39:0] acc0;      // Low-pass accumulator
	reg  signed [39:0] acc1;      // Band-pass accumulator
	reg  signed [39:0] acc2;      // High-pass accumulator
	reg  [31:0] en0;              // Block energy per channel
	reg  [31:0] en1;
	reg  [31:0] en2;
	reg  [13:0] refresh;          // Samples since last indicator update
	reg         sw_d;             // Switch edge history
	reg  [7:0]  blk_cnt;          // Samples per judgement block
	integer     i;
	wire [11:0] buf_data;
	wire        buf_valid;
	wire        buf_ready;
	wire [15:0] norm = normalise(buf_data);
	// Newest stored word, read back so bypass shows what the buffer holds
	wire [15:0] last_norm = normalise(in_buf[wr_idx - 8'h01]);

	// Offset-binary to signed, then scale by one shift: 12 to 15 bits
	function [15:0] normalise;
		input [11:0] raw;
		reg   [11:0] cen;
		begin
			cen       = raw - `BSF_BIAS;
			normalise = {cen[11], cen, 3'b000};
		end
	endfunction

	// Coefficient table; plain rectangular shapes, small magnitudes
	function signed [15:0] coef;
		input [1:0] ch;
		input [5:0] k;
		begin
			case (ch)
				2'h0:    coef = 16'sh0100;                             // Moving average
				2'h1:    coef = k[1] ? -16'sh0100 : 16'sh0100;         // Quarter-rate band
				default: coef = k[0] ? -16'sh0100 : 16'sh0100;         // Alternating, high
			endcase
		end
	endfunction

	// Magnitude of a filter output
	function [15:0] mag;
		input [15:0] v;
		begin
			mag = v[15] ? (~v + 16'h0001) : v;
		end
	endfunction

	// Conversion results queue here, two deep; in_ready is left open, so a word arriving when full is lost
	bsf_skid #(.W(12)) u_skid (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (conv_data),
		.in_valid  (conv_valid),
		.in_ready  (),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (buf_ready)
	);
	assign buf_ready = (state == S_IDLE);

	// Match timer and routed conversion start
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr        <= 15'h0000;
			conv_start <= 1'b0;
		end else if (tmr == `BSF_SAMPLE_CYC - 1) begin
			tmr        <= 15'h0000;
			conv_start <= 1'b1;
		end else begin
			tmr        <= tmr + 15'h0001;
			conv_start <= 1'b0;
		end
	end

	// Transfer engine: raw word into input buffer, done after 256
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_idx     <= 8'h00;
			block_done <= 1'b0;
		end else begin
			block_done <= 1'b0;
			if (buf_valid && buf_ready) begin
				in_buf[wr_idx] <= buf_data;
				wr_idx         <= wr_idx + 8'h01;
				if (wr_idx == `BSF_BLOCK_LEN - 1)
					block_done <= 1'b1;
			end
		end
	end

	// Press toggles filtering; edge only, a held switch does nothing
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_d      <= 1'b0;
			filter_on <= 1'b1;
		end else begin
			sw_d <= filter_switch;
			if (filter_switch && !sw_d)
				filter_on <= ~filter_on;
		end
	end

	// FIR sequencer: shift in, run taps, publish; one tap per cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= S_IDLE;
			tap       <= 6'h00;
			acc0      <= 40'sh0;
			acc1      <= 40'sh0;
			acc2      <= 40'sh0;
			ch0_out   <= 16'h0000;
			ch1_out   <= 16'h0000;
			ch2_out   <= 16'h0000;
			ch_valid  <= 1'b0;
			for (i = 0; i < TAPS; i = i + 1)
				hist[i] <= 16'h0000;
		end else begin
			ch_valid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (buf_valid) begin
						hist[0]   <= norm;
						for (i = 1; i < TAPS; i = i + 1)
							hist[i] <= hist[i-1];
						acc0  <= 40'sh0;
						acc1  <= 40'sh0;
						acc2  <= 40'sh0;
						tap   <= 6'h00;
						state <= S_MAC;
					end
				end
				S_MAC: begin
					// Only 16-bit fixed is built; other modes run the same path
					acc0 <= acc0 + $signed(hist[tap]) * coef(2'h0, tap);
					acc1 <= acc1 + $signed(hist[tap]) * coef(2'h1, tap);
					acc2 <= acc2 + $signed(hist[tap]) * coef(2'h2, tap);
					tap  <= tap + 6'h01;
					if (tap == TAPS - 1)
						state <= S_OUT;
				end
				S_OUT: begin
					if (filter_on) begin
						ch0_out <= acc0[29:14];
						ch1_out <= acc1[29:14];
						ch2_out <= acc2[29:14];
					end else begin
						ch0_out <= last_norm;
						ch1_out <= last_norm;
						ch2_out <= last_norm;
					end
					ch_valid <= 1'b1;
					state    <= S_HOLD;
				end
				S_HOLD:  state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// Energy per block, judgement, indicator refresh about 1 s
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en0     <= 32'h0000_0000;
			en1     <= 32'h0000_0000;
			en2     <= 32'h0000_0000;
			blk_cnt <= 8'h00;
			refresh <= 14'h0000;
			led     <= 2'h0;
		end else if (ch_valid) begin
			blk_cnt <= blk_cnt + 8'h01;
			if (refresh != `BSF_REFRESH_CNT - 1)
				refresh <= refresh + 14'h0001;
			if (blk_cnt == `BSF_BLOCK_LEN - 1) begin
				en0 <= 32'h0000_0000;
				en1 <= 32'h0000_0000;
				en2 <= 32'h0000_0000;
				if (refresh == `BSF_REFRESH_CNT - 1) begin
					refresh <= 14'h0000;
					if (en0 >= en1 && en0 >= en2)
						led <= `BSF_BAND_LOW;
					else if (en1 >= en2)
						led <= `BSF_BAND_MID;
					else
						led <= `BSF_BAND_HIGH;
				end
			end else begin
				en0 <= en0 + {16'h0000, mag(ch0_out)};
				en1 <= en1 + {16'h0000, mag(ch1_out)};
				en2 <= en2 + {16'h0000, mag(ch2_out)};
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/bsf_checker.sv ====
/* Port checker for bsf_top.
 Assumes a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module bsf_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        conv_valid,
	input wire logic        filter_switch,
	input wire logic        conv_start,
	input wire logic        block_done,
	input wire logic        filter_on,
	input wire logic [1:0]  led,
	input wire logic [15:0] ch0_out,
	input wire logic [15:0] ch1_out,
	input wire logic [15:0] ch2_out,
	input wire logic        ch_valid
);
	logic [14:0] gap;   // Cycles since last start
	logic [7:0]  takes; // Words taken, mod 256
	logic [13:0] outs;  // Outputs so far, held at 10000
	// Counters behind the timing checks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 15'h0000;
			takes <= 8'h00;
			outs <= 14'h0000;
		end else begin
			if (ch_valid && outs != 14'h2710)
				outs <= outs + 14'h0001;
			gap <= conv_start ? 15'h0000 : gap + 15'h0001;
			takes <= takes + {7'h00, conv_valid};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_last_take;
		conv_valid && takes == 8'hff;
	endsequence
	sequence s_bypass_out;
		ch_valid && !filter_on;
	endsequence
	a_start_period: assert property (conv_start |-> gap >= 15'h4e1e && gap <= 15'h4e21)
		else $error("start spacing wrong");
	a_start_late: assert property (gap <= 15'h4e21)
		else $error("start overdue");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start too long");
	a_block_end: assert property (s_last_take |-> ##[1:3] block_done)
		else $error("block done missing");
	a_done_cause: assert property (block_done |-> takes == 8'h00)
		else $error("block done early");
	a_answer_time: assert property (conv_valid |-> ##[60:75] ch_valid)
		else $error("no channel output");
	a_out_hold: assert property (!ch_valid |-> $stable(ch0_out) && $stable(ch1_out) && $stable(ch2_out))
		else $error("outputs moved");
	a_bypass_same: assert property (s_bypass_out |-> ch0_out == ch1_out && ch1_out == ch2_out)
		else $error("bypass channels differ");
	a_norm_shape: assert property (s_bypass_out |-> ch0_out[2:0] == 3'h0 && ch0_out[15] == ch0_out[14])
		else $error("bad normalised shape");
	a_switch_flip: assert property ($rose(filter_switch) |-> ##[1:2] $changed(filter_on))
		else $error("filter did not toggle");
	a_led_wait: assert property (outs < 14'h2710 |-> led == 2'h0)
		else $error("indicator refreshed too early");
endmodule
`default_nettype wire

// ==== verif/bsf_src.sv ====
/* Converter model: answers each trigger after dly+1 cycles.
 Assumes level is valid when the trigger is sampled; it is latched then. */
`timescale 1ns/1ps
`default_nettype none
module bsf_src (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        trig,
	input  wire logic [3:0]  dly,
	input  wire logic [11:0] level,
	output logic             conv_valid,
	output logic [11:0]      conv_data
);
	logic [4:0]  cnt;  // Pending answer delay
	logic [11:0] held; // Sampled level
	// One conversion per trigger, 12-bit unsigned result
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5'h00;
			held <= 12'h000;
			conv_valid <= 1'b0;
			conv_data <= 12'h000;
		end else begin
			conv_valid <= 1'b0;
			// Data not held outside the strobe
			conv_data <= ~conv_data;
			if (trig) begin
				cnt <= {1'b0, dly} + 5'h01;
				held <= level;
			end else if (cnt == 5'h01) begin
				conv_valid <= 1'b1;
				conv_data <= held;
				cnt <= 5'h00;
			end else if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb_bsf_top.sv ====
/* Bench for bsf_top with converter model and queued compares.
 Assumes bsf_src and bsf_checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_bsf_top;
	logic        clk, rst_n, kick, filter_switch, bypass;
	logic        conv_valid, conv_start, block_done, filter_on, ch_valid;
	logic [3:0]  dly;
	logic [11:0] level, conv_data;
	logic [1:0]  led;
	logic [15:0] ch0_out, ch1_out, ch2_out;
	logic [16:0] e;
	logic signed [15:0] hb [0:63]; // Last 64 normalised samples, newest first
	logic signed [31:0] sum;       // Their sum
	logic [16:0] exp_q[$]; // Check flag and value
	integer      fail_count, num_checks, seed, cyc, dones, takes, i, j;
	bsf_top i_dut (.clk(clk), .rst_n(rst_n), .conv_valid(conv_valid), .conv_data(conv_data),
		.filter_switch(filter_switch), .arith_mode(2'h0), .conv_start(conv_start), .block_done(block_done),
		.filter_on(filter_on), .led(led), .ch0_out(ch0_out), .ch1_out(ch1_out), .ch2_out(ch2_out),
		.ch_valid(ch_valid));
	bsf_src i_src (.clk(clk), .rst_n(rst_n), .trig(conv_start | kick), .dly(dly), .level(level),
		.conv_valid(conv_valid), .conv_data(conv_data));
	// Bias removal then x8 into 16 bits
	function automatic logic [15:0] norm(input logic [11:0] raw);
		norm = {~raw[11], ~raw[11], raw[10:0], 3'h0};
	endfunction
	task automatic check(input string what, input logic [15:0] x, input logic [15:0] s);
		num_checks = num_checks + 1;
		if (s !== x) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, x, s);
		end
	endtask
	task automatic final_report;
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Kicks 80 cycles apart, edge levels first
	task automatic sample(input integer n);
		repeat (n) begin
			@(posedge clk);
			level <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : $random(seed);
			dly <= $random(seed) & 4'h7;
			kick <= 1'b1;
			i = i + 1;
			@(posedge clk);
			kick <= 1'b0;
			repeat (78) @(posedge clk);
		end
	endtask
	task automatic press;
		@(posedge clk);
		filter_switch <= 1'b1;
		repeat (4) @(posedge clk);
		filter_switch <= 1'b0;
		bypass = !bypass;
		check("filter_on", {15'h0000, !bypass}, {15'h0000, filter_on});
	endtask
	task automatic next_start;
		@(posedge clk);
		while (conv_start !== 1'b1)
			@(posedge clk);
		repeat (80) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Note each driven word, compare each output; ch1 and ch2 only in bypass
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 45000) begin
			fail_count = fail_count + 1;
			final_report;
		end else begin
			if (rst_n && conv_valid) begin
				takes = takes + 1;
				for (j = 63; j > 0; j = j - 1)
					hb[j] = hb[j-1];
				hb[0] = norm(conv_data);
				sum = 32'sh0000_0000;
				for (j = 0; j < 64; j = j + 1)
					sum = sum + hb[j];
				// Low-pass reference: unity-gain mean of the last 64 samples
				exp_q.push_back({bypass, bypass ? hb[0] : 16'(sum >>> 6)});
			end
			if (rst_n && block_done) begin
				dones = dones + 1;
				check("takes", 16'h0100, takes[15:0]);
			end
			if (rst_n && ch_valid) begin
				if (exp_q.size() == 0)
					check("queue", 16'h0001, 16'h0000);
				else begin
					e = exp_q.pop_front();
					check("ch0", e[15:0], ch0_out);
					if (e[16]) begin
						check("ch1", e[15:0], ch1_out);
						check("ch2", e[15:0], ch2_out);
					end
				end
			end
		end
	end
	initial begin
		{rst_n, kick, filter_switch, bypass, dly, level} = 0;
		{fail_count, num_checks, cyc, dones, takes, i} = 0;
		for (j = 0; j < 64; j = j + 1)
			hb[j] = 16'sh0000;
		seed = 32'h60f2;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		check("filter_on", 16'h0001, {15'h0000, filter_on});
		sample(8);
		press;
		next_start;
		sample(247);
		press;
		next_start;
		sample(2);
		check("block_done", 16'h0001, dones[15:0]);
		check("queue", 16'h0000, 16'(exp_q.size()));
		// Far fewer than 10000 outputs so far, so no judgement shown yet
		check("led", 16'h0000, {14'h0000, led});
		final_report;
	end
endmodule
bind bsf_top bsf_checker i_chk (.clk(clk), .rst_n(rst_n), .conv_valid(conv_valid), .filter_switch(filter_switch),
	.conv_start(conv_start), .block_done(block_done), .filter_on(filter_on), .led(led), .ch0_out(ch0_out),
	.ch1_out(ch1_out), .ch2_out(ch2_out), .ch_valid(ch_valid));
`default_nettype wire
